// ### src/codec_ctl_pkg.sv
package codec_ctl_pkg;

    // Synchronised pin vector layout
    localparam int SYNC_W = 6;
    localparam int SY_CLK = 0;
    localparam int SY_DIN = 1;
    localparam int SY_CSAD0 = 2;
    localparam int SY_AD1 = 3;
    localparam int SY_RSTN = 4;
    localparam int SY_PLL = 5;

    // Bus addresses
    localparam logic [6:0] SPI_CHIP_ADDR = 7'h4F;
    localparam logic [4:0] I2C_ADDR_HI = 5'h13;

    // Register space
    localparam int REG_N = 128;
    localparam int PTR_W = 7;
    localparam int AUTOINC_BIT = 7;
    localparam logic [6:0] REG_POWER = 7'h02;
    localparam logic [6:0] REG_IFMT = 7'h04;
    localparam logic [6:0] REG_CLOCK = 7'h06;
    localparam logic [6:0] REG_VOLCTL = 7'h0D;
    localparam logic [6:0] REG_INT_STATUS = 7'h20;
    localparam logic [6:0] REG_INT_MASK = 7'h21;
    localparam logic [6:0] REG_INT_MODE_LO = 7'h22;
    localparam logic [6:0] REG_INT_MODE_HI = 7'h23;
    localparam logic [6:0] REG_INT_PIN = 7'h24;
    localparam int PDN_BIT = 0;
    localparam int PLL_SEL_BIT = 1;
    localparam logic [7:0] POWER_RST = 8'h01;
    localparam logic [7:0] IFMT_RST = 8'h40;
    localparam logic [7:0] VOLCTL_RST = 8'h08;

    // Interrupt configuration
    localparam int INT_N = 8;
    localparam logic [1:0] INT_ACT_LOW = 2'h0;
    localparam logic [1:0] INT_ACT_HIGH = 2'h1;
    localparam logic [1:0] INT_OPEN_DRAIN = 2'h2;
    localparam logic [1:0] SRC_LEVEL = 2'h0;
    localparam logic [1:0] SRC_RISE = 2'h1;
    localparam logic [1:0] SRC_FALL = 2'h2;

    // Reference ramp mute time
    localparam int VREF_RAMP_MS = 80;
    localparam int CLK_MHZ = 250;
    localparam int VREF_RAMP_CYCLES = VREF_RAMP_MS * 1000 * CLK_MHZ;
    localparam int RAMP_W = 25;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_MAP = 3'h2,
        ST_WDATA = 3'h3,
        ST_RDATA = 3'h4,
        ST_DACK = 3'h5,
        ST_HACK = 3'h6,
        ST_SKIP = 3'h7
    } xfer_state_t;

    function automatic logic [7:0] regReset(input logic [6:0] idx);
        case (idx)
            REG_POWER: return POWER_RST;
            REG_IFMT: return IFMT_RST;
            REG_VOLCTL: return VOLCTL_RST;
            default: return 8'h00;
        endcase
    endfunction

endpackage

// ### src/input_sync.sv
module input_sync (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [codec_ctl_pkg::SYNC_W-1:0] rawIn,
    output logic [codec_ctl_pkg::SYNC_W-1:0] level
);
    import codec_ctl_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] lvl;
    } sync_state_t;

    sync_state_t s, next_s;
    logic [SYNC_W-1:0] nextLvl;

    // Level moves only once the second and third stages agree
    for (genvar g = 0; g < SYNC_W; g++) begin : g_bit
        assign nextLvl[g] = (s.s2[g] == s.s3[g]) ? s.s3[g] : s.lvl[g];
    end

    always_comb begin
        next_s = s;
        next_s.s1 = rawIn;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        next_s.lvl = nextLvl;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level = s.lvl;

endmodule // input_sync

// ### src/codec_control_port.sv
// Function
// RULE1 - Falling edge on chip select after reset release selects four-wire mode
// RULE2 - In two-wire mode strap levels caught during reset form address bits
// RULE3 - Four-wire input sampled on clock rise, output shifted on clock fall
// RULE4 - Host sends chip address 1001111 then direction bit, low for write
// RULE5 - Four-wire write: pointer byte first, then data into pointed register
// RULE6 - Pointer is eight bits, most significant bit first
// RULE7 - Four-wire serial output stays released during writes
// RULE8 - Pointer advances per byte when autoincrement set, else unchanged
// RULE9 - Host sets pointer by partial write before a four-wire read
// RULE10 - Four-wire read drives register MSB on first fall after direction
// RULE11 - Two-wire address is 10011 plus straps; eighth bit high for read
// RULE12 - Two-wire write: first byte is pointer, later bytes stored
// RULE13 - Two-wire read returns pointed register, continuing when autoincrement
// RULE14 - Device acknowledges received bytes; host acknowledges sent bytes
// RULE15 - Host loads pointer with a pointer-only write ended by stop
// RULE16 - Interrupt pin active low, active high, or open-drain low
// RULE17 - Each interrupt source has a mask and rise, fall or level mode
// RULE18 - Reset pin low holds all state and registers reset, muted, low power
// RULE19 - After reset writes accepted; power-down bit cleared leaves low power
// RULE20 - With PLL selected, audio outputs stay disabled until PLL locks
// RULE21 - Outputs muted for about 80 ms after reset exit
// RULE22 - Port runs asynchronously; host keeps pins static when idle
// RULE23 - Register updates reach audio logic only through this clock domain
module codec_control_port #(
    parameter int unsigned RAMP_CYCLES = codec_ctl_pkg::VREF_RAMP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic controlBitClock,
    input wire logic controlSerialIn,
    input wire logic addr0OrChipSelect,
    input wire logic addrStrapBit1,
    input wire logic resetPinN,
    input wire logic pllLocked,
    input wire logic [codec_ctl_pkg::INT_N-1:0] intSource,
    output logic controlSerialOut,
    output logic controlSerialOutEnN,
    output logic dataPinOut,
    output logic dataPinEnN,
    output logic intPinOut,
    output logic intPinEnN,
    output logic globalPowerDown,
    output logic muteOut,
    output logic audioOutEnable,
    output logic spiModeActive,
    output logic [7:0] powerControl
);
    import codec_ctl_pkg::*;

    typedef struct packed {
        xfer_state_t st;
        xfer_state_t ackNext;
        logic spiMode;
        logic [1:0] strap;
        logic [2:0] bitCnt;
        logic byteDone;
        logic rw;
        logic [7:0] shiftIn;
        logic [7:0] shiftOut;
        logic [7:0] map;
        logic txFirst;
        logic hostAck;
        logic lastClk;
        logic lastDin;
        logic lastCs;
        logic sdo;
        logic sdoEnN;
        logic sdaOut;
        logic sdaEnN;
        logic [INT_N-1:0] srcPrev;
        logic [INT_N-1:0] sticky;
        logic intOut;
        logic intEnN;
        logic [RAMP_W-1:0] ramp;
        logic muted;
        logic lowPower;
        logic audioEn;
    } ctl_state_t;

    localparam ctl_state_t CTL_RST = '{
        st: ST_IDLE, ackNext: ST_IDLE, sdoEnN: 1'b1, sdaEnN: 1'b1,
        intOut: 1'b1, intEnN: 1'b1, muted: 1'b1, lowPower: 1'b1,
        default: '0
    };
    localparam logic [RAMP_W-1:0] RAMP_END = RAMP_W'(RAMP_CYCLES - 1);

    ctl_state_t s, next_s;
    logic [SYNC_W-1:0] lvl;
    logic [7:0] regs [REG_N];
    logic wrEn;
    logic [PTR_W-1:0] wrIdx;
    logic [7:0] wrData;
    logic clrStatus;
    logic [INT_N-1:0] evt;
    logic [INT_N-1:0] statusView;
    logic inReset;
    logic din;
    logic csLvl;
    logic clkRise;
    logic clkFall;
    logic csFall;
    logic sdaStart;
    logic sdaStop;
    logic intActive;
    logic pllBlocks;

    input_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .rawIn({pllLocked, resetPinN, addrStrapBit1, addr0OrChipSelect,
                controlSerialIn, controlBitClock}),
        .level(lvl)
    );

    assign inReset = ~lvl[SY_RSTN];
    assign din = lvl[SY_DIN];
    assign csLvl = lvl[SY_CSAD0];
    assign clkRise = ~s.lastClk & lvl[SY_CLK];
    assign clkFall = s.lastClk & ~lvl[SY_CLK];
    assign csFall = s.lastCs & ~csLvl;
    assign sdaStart = s.lastClk & lvl[SY_CLK] & s.lastDin & ~din;
    assign sdaStop = s.lastClk & lvl[SY_CLK] & ~s.lastDin & din;
    assign pllBlocks = regs[REG_CLOCK][PLL_SEL_BIT] & ~lvl[SY_PLL];

    // Per-source edge or level detection
    for (genvar g = 0; g < INT_N; g++) begin : g_src
        logic [1:0] mode;
        assign mode = {regs[REG_INT_MODE_HI][g], regs[REG_INT_MODE_LO][g]};
        assign evt[g] = (mode == SRC_RISE) ? (intSource[g] & ~s.srcPrev[g])
                      : (mode == SRC_FALL) ? (~intSource[g] & s.srcPrev[g])
                      : 1'b0; // see RULE17
        assign statusView[g] = (mode == SRC_RISE || mode == SRC_FALL)
                             ? s.sticky[g] : intSource[g];
    end
    assign intActive = |(statusView & regs[REG_INT_MASK]); // see RULE17

    function automatic logic [7:0] rdData(input logic [PTR_W-1:0] idx);
        return (idx == REG_INT_STATUS) ? statusView : regs[idx];
    endfunction

    always_comb begin
        logic [7:0] byteIn;
        logic [7:0] data;
        logic loadTx;
        logic [PTR_W-1:0] loadIdx;
        byteIn = '0;
        data = '0;
        loadTx = 1'b0;
        loadIdx = s.map[PTR_W-1:0];
        next_s = s;
        wrEn = 1'b0;
        wrIdx = s.map[PTR_W-1:0];
        wrData = '0;
        clrStatus = 1'b0;
        next_s.lastClk = lvl[SY_CLK];
        next_s.lastDin = din;
        next_s.lastCs = csLvl;
        if (!s.spiMode && csFall) begin
            next_s.spiMode = 1'b1; // see RULE1
            next_s.st = ST_ADDR;
            next_s.bitCnt = 3'h0;
        end else if (s.spiMode) begin
            if (csLvl) begin
                next_s.st = ST_IDLE;
                next_s.sdoEnN = 1'b1; // see RULE7
            end else if (csFall) begin
                next_s.st = ST_ADDR;
                next_s.bitCnt = 3'h0;
            end else if (clkRise && (s.st == ST_ADDR || s.st == ST_MAP ||
                                     s.st == ST_WDATA)) begin
                byteIn = {s.shiftIn[6:0], din}; // see RULE3, RULE6
                next_s.shiftIn = byteIn;
                next_s.bitCnt = s.bitCnt + 3'h1;
                if (s.bitCnt == 3'h7) begin
                    case (s.st)
                        ST_ADDR: begin
                            if (byteIn[7:1] == SPI_CHIP_ADDR) begin // see RULE4
                                next_s.rw = byteIn[0];
                                next_s.st = byteIn[0] ? ST_RDATA : ST_MAP;
                                next_s.txFirst = 1'b1;
                            end else begin
                                next_s.st = ST_SKIP;
                            end
                        end
                        ST_MAP: begin
                            next_s.map = byteIn; // see RULE5
                            next_s.st = ST_WDATA;
                        end
                        default: begin
                            wrEn = 1'b1; // see RULE5
                            wrData = byteIn;
                            if (s.map[AUTOINC_BIT]) begin
                                next_s.map[PTR_W-1:0] =
                                    s.map[PTR_W-1:0] + 7'h01; // see RULE8
                            end
                        end
                    endcase
                end
            end else if (clkFall && s.st == ST_RDATA) begin
                if (s.bitCnt == 3'h0) begin
                    loadTx = 1'b1; // see RULE10
                    loadIdx = (!s.txFirst && s.map[AUTOINC_BIT])
                            ? s.map[PTR_W-1:0] + 7'h01
                            : s.map[PTR_W-1:0]; // see RULE8
                    next_s.map[PTR_W-1:0] = loadIdx;
                    next_s.txFirst = 1'b0;
                end else begin
                    next_s.sdo = s.shiftOut[7]; // see RULE3
                    next_s.shiftOut = {s.shiftOut[6:0], 1'b0};
                    next_s.bitCnt = s.bitCnt + 3'h1;
                end
            end
        end else begin
            if (sdaStart) begin
                next_s.st = ST_ADDR;
                next_s.bitCnt = 3'h0;
                next_s.byteDone = 1'b0;
                next_s.sdaEnN = 1'b1;
            end else if (sdaStop) begin
                next_s.st = ST_IDLE;
                next_s.sdaEnN = 1'b1;
            end else if (clkRise) begin
                case (s.st)
                    ST_ADDR, ST_MAP, ST_WDATA: begin
                        next_s.shiftIn = {s.shiftIn[6:0], din};
                        next_s.bitCnt = s.bitCnt + 3'h1;
                        next_s.byteDone = (s.bitCnt == 3'h7);
                    end
                    ST_RDATA: begin
                        next_s.bitCnt = s.bitCnt + 3'h1;
                        next_s.byteDone = (s.bitCnt == 3'h7);
                    end
                    ST_HACK: next_s.hostAck = ~din; // see RULE14
                    default: ;
                endcase
            end else if (clkFall) begin
                case (s.st)
                    ST_ADDR, ST_MAP, ST_WDATA: begin
                        if (s.byteDone) begin
                            next_s.byteDone = 1'b0;
                            next_s.sdaEnN = 1'b0; // see RULE14
                            next_s.st = ST_DACK;
                            next_s.ackNext = ST_WDATA;
                            if (s.st == ST_ADDR) begin
                                if (s.shiftIn[7:1] ==
                                    {I2C_ADDR_HI, s.strap}) begin // see RULE11
                                    next_s.rw = s.shiftIn[0];
                                    next_s.ackNext = s.shiftIn[0]
                                                   ? ST_RDATA : ST_MAP;
                                end else begin
                                    next_s.sdaEnN = 1'b1;
                                    next_s.st = ST_SKIP;
                                end
                            end else if (s.st == ST_MAP) begin
                                next_s.map = s.shiftIn; // see RULE12
                            end else begin
                                wrEn = 1'b1; // see RULE12
                                wrData = s.shiftIn;
                                if (s.map[AUTOINC_BIT]) begin
                                    next_s.map[PTR_W-1:0] =
                                        s.map[PTR_W-1:0] + 7'h01;
                                end
                            end
                        end
                    end
                    ST_DACK: begin
                        next_s.sdaEnN = 1'b1;
                        next_s.bitCnt = 3'h0;
                        if (s.ackNext == ST_RDATA) begin
                            loadTx = 1'b1; // see RULE13
                        end else begin
                            next_s.st = s.ackNext;
                        end
                    end
                    ST_RDATA: begin
                        if (s.byteDone) begin
                            next_s.byteDone = 1'b0;
                            next_s.sdaEnN = 1'b1;
                            next_s.st = ST_HACK;
                            if (s.map[AUTOINC_BIT]) begin
                                next_s.map[PTR_W-1:0] =
                                    s.map[PTR_W-1:0] + 7'h01; // see RULE13
                            end
                        end else begin
                            next_s.sdaEnN = s.shiftOut[7];
                            next_s.shiftOut = {s.shiftOut[6:0], 1'b0};
                        end
                    end
                    ST_HACK: begin
                        if (s.hostAck) begin
                            loadTx = 1'b1;
                        end else begin
                            next_s.st = ST_SKIP;
                        end
                    end
                    default: ;
                endcase
            end
        end
        if (loadTx) begin
            data = rdData(loadIdx);
            clrStatus = (loadIdx == REG_INT_STATUS);
            next_s.shiftOut = {data[6:0], 1'b0};
            next_s.st = ST_RDATA;
            if (s.spiMode) begin
                next_s.sdo = data[7];
                next_s.sdoEnN = 1'b0;
                next_s.bitCnt = 3'h1;
            end else begin
                next_s.sdaEnN = data[7];
                next_s.bitCnt = 3'h0;
            end
        end
        // Set wins over the clear-on-read
        next_s.srcPrev = intSource;
        next_s.sticky = (s.sticky & ~{INT_N{clrStatus}}) | evt;
        case (regs[REG_INT_PIN][1:0])
            INT_ACT_HIGH: begin
                next_s.intOut = intActive; // see RULE16
                next_s.intEnN = 1'b0;
            end
            INT_OPEN_DRAIN: begin
                next_s.intOut = 1'b0; // see RULE16
                next_s.intEnN = ~intActive;
            end
            default: begin
                next_s.intOut = ~intActive; // see RULE16
                next_s.intEnN = 1'b0;
            end
        endcase
        if (s.muted) begin
            if (s.ramp >= RAMP_END) begin
                next_s.muted = 1'b0; // see RULE21
            end else begin
                next_s.ramp = s.ramp + 1'b1;
            end
        end
        next_s.lowPower = regs[REG_POWER][PDN_BIT]; // see RULE19
        next_s.audioEn = ~s.muted & ~regs[REG_POWER][PDN_BIT] &
                         ~pllBlocks; // see RULE20, RULE23
        if (inReset) begin
            next_s = CTL_RST; // see RULE18
            next_s.strap = {lvl[SY_AD1], csLvl}; // see RULE2
            next_s.lastClk = lvl[SY_CLK];
            next_s.lastDin = din;
            next_s.lastCs = csLvl;
            wrEn = 1'b0;
            clrStatus = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= CTL_RST;
        end else begin
            s <= next_s;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < REG_N; i++) begin
                regs[i] <= regReset(PTR_W'(i));
            end
        end else if (inReset) begin
            for (int i = 0; i < REG_N; i++) begin
                regs[i] <= regReset(PTR_W'(i)); // see RULE18
            end
        end else if (wrEn && wrIdx != REG_INT_STATUS) begin
            regs[wrIdx] <= wrData; // see RULE19
        end
    end

    assign controlSerialOut = s.sdo;
    assign controlSerialOutEnN = s.sdoEnN;
    assign dataPinOut = s.sdaOut;
    assign dataPinEnN = s.sdaEnN;
    assign intPinOut = s.intOut;
    assign intPinEnN = s.intEnN;
    assign globalPowerDown = s.lowPower;
    assign muteOut = s.muted;
    assign audioOutEnable = s.audioEn;
    assign spiModeActive = s.spiMode;
    assign powerControl = regs[REG_POWER];

    property p_spi_enter;
        @(posedge ref_clk) disable iff (rst)
        (!s.spiMode && csFall && !inReset) |=> s.spiMode;
    endproperty
    a_spi_enter: assert property (p_spi_enter) // see RULE1
        else $error("four-wire mode not entered on select fall");

    property p_strap;
        @(posedge ref_clk) disable iff (rst)
        inReset |=> (s.strap == $past({lvl[SY_AD1], csLvl}));
    endproperty
    a_strap: assert property (p_strap) // see RULE2
        else $error("strap levels not captured in reset");

    property p_sdo_hiz;
        @(posedge ref_clk) disable iff (rst)
        (s.spiMode && (s.st == ST_MAP || s.st == ST_WDATA)) |-> s.sdoEnN;
    endproperty
    a_sdo_hiz: assert property (p_sdo_hiz) // see RULE7
        else $error("serial output driven during write");

    property p_inc_off;
        @(posedge ref_clk) disable iff (rst)
        (wrEn && !s.map[AUTOINC_BIT]) |=> (s.map == $past(s.map));
    endproperty
    a_inc_off: assert property (p_inc_off) // see RULE8
        else $error("pointer moved with autoincrement off");

    property p_inc_on;
        @(posedge ref_clk) disable iff (rst)
        (wrEn && s.map[AUTOINC_BIT]) |=>
            (s.map[PTR_W-1:0] == $past(s.map[PTR_W-1:0]) + 7'h01);
    endproperty
    a_inc_on: assert property (p_inc_on) // see RULE8
        else $error("pointer not advanced with autoincrement on");

    // Index and data the first fall of a read byte should load
    logic [PTR_W-1:0] loadIdxChk;
    logic [7:0] loadChkData;
    assign loadIdxChk = (!s.txFirst && s.map[AUTOINC_BIT])
                      ? s.map[PTR_W-1:0] + 7'h01 : s.map[PTR_W-1:0];
    assign loadChkData = rdData(loadIdxChk);

    property p_read_drive;
        @(posedge ref_clk) disable iff (rst)
        (s.spiMode && !csLvl && !inReset && s.st == ST_RDATA && clkFall &&
         s.bitCnt == 3'h0) |=> (!s.sdoEnN && s.sdo == $past(loadChkData[7]));
    endproperty
    a_read_drive: assert property (p_read_drive) // see RULE10
        else $error("read data not driven on first fall");

    property p_ack;
        @(posedge ref_clk) disable iff (rst)
        (!s.spiMode && s.st == ST_DACK) |-> !s.sdaEnN;
    endproperty
    a_ack: assert property (p_ack) // see RULE14
        else $error("acknowledge not driven");

    property p_reset_hold;
        @(posedge ref_clk) disable iff (rst)
        inReset |=> (s.st == ST_IDLE && s.lowPower && s.muted);
    endproperty
    a_reset_hold: assert property (p_reset_hold) // see RULE18
        else $error("state not held during reset");

    property p_pll_gate;
        @(posedge ref_clk) disable iff (rst)
        s.audioEn |-> $past(!pllBlocks);
    endproperty
    a_pll_gate: assert property (p_pll_gate) // see RULE20
        else $error("audio enabled before pll lock");

    property p_ramp_mute;
        @(posedge ref_clk) disable iff (rst)
        $fell(inReset) |-> s.muted [*8];
    endproperty
    a_ramp_mute: assert property (p_ramp_mute) // see RULE21
        else $error("mute released too soon after reset");

endmodule // codec_control_port

// ### bench/host_model.sv
module host_model (
    input wire logic ref_clk,
    input wire logic sdo,
    input wire logic sdoEnN,
    input wire logic sda,
    output logic sclk,
    output logic din,
    output logic selN
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclk = 1'b1;
        din = 1'b0;
        selN = 1'b1;
    end

    // Clock parks high; a released data line flips so stale bits never match
    task automatic sel(input logic v);
        @(posedge ref_clk);
        selN <= v;
        if (v) begin
            din <= ~din;
        end
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic xbyte(input logic [7:0] w, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            @(posedge ref_clk);
            sclk <= 1'b0;
            din <= w[i];
            repeat (8) @(posedge ref_clk);
            sclk <= 1'b1;
            r[i] = sdoEnN ? ~sdo : sdo;
            repeat (7) @(posedge ref_clk);
        end
    endtask

    // Start when v is high, stop when low; clock high on exit
    task automatic i2c_edge(input logic v);
        @(posedge ref_clk);
        sclk <= 1'b0;
        din <= v;
        repeat (8) @(posedge ref_clk);
        sclk <= 1'b1;
        repeat (8) @(posedge ref_clk);
        din <= ~v;
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic i2c_byte(input logic [7:0] w, output logic ack);
        logic [7:0] r;
        xbyte(w, r);
        @(posedge ref_clk);
        sclk <= 1'b0;
        din <= 1'b1;
        repeat (8) @(posedge ref_clk);
        sclk <= 1'b1;
        ack = ~sda;
        repeat (7) @(posedge ref_clk);
    endtask
endmodule // host_model

// ### bench/codec_control_port_tb_top.sv
module codec_control_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import codec_ctl_pkg::*;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic resetPinN = 1'b0;
    logic sclk, din, selN, sdo, sdoEnN, sdaLine, dataEnN;
    logic inWrite = 1'b0, enSeen = 1'b0;
    logic gpd, mute, spiOn, intPin, audioEn, pllOk = 1'b0;
    logic [7:0] pwr, r0, r1, dum, intSrc = 8'h00;
    int error_cnt = 0;
    int num_checks = 0;

    codec_control_port #(.RAMP_CYCLES(32)) codec_control_port_inst (
        .ref_clk(ref_clk), .rst(rst), .controlBitClock(sclk),
        .controlSerialIn(sdaLine), .addr0OrChipSelect(selN),
        .addrStrapBit1(1'b0), .resetPinN(resetPinN), .pllLocked(pllOk),
        .intSource(intSrc), .controlSerialOut(sdo),
        .controlSerialOutEnN(sdoEnN), .dataPinOut(), .dataPinEnN(dataEnN),
        .intPinOut(intPin), .intPinEnN(), .globalPowerDown(gpd),
        .muteOut(mute), .audioOutEnable(audioEn), .spiModeActive(spiOn),
        .powerControl(pwr)
    );

    host_model host_model_inst (
        .ref_clk(ref_clk), .sdo(sdo), .sdoEnN(sdoEnN), .sda(sdaLine),
        .sclk(sclk), .din(din), .selN(selN)
    );

    // Shared data line: host and device only pull it low
    assign sdaLine = din & dataEnN;

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (inWrite && sdoEnN !== 1'b1) begin
            enSeen <= 1'b1;
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, p, d0, d1, input int n);
        inWrite = 1'b1;
        host_model_inst.sel(1'b0);
        host_model_inst.xbyte(a, dum);
        host_model_inst.xbyte(p, dum);
        if (n > 0) host_model_inst.xbyte(d0, dum);
        if (n > 1) host_model_inst.xbyte(d1, dum);
        host_model_inst.sel(1'b1);
        inWrite = 1'b0;
    endtask

    task automatic rd(input logic [7:0] p);
        wr(8'h9E, p, 8'h00, 8'h00, 0);
        host_model_inst.sel(1'b0);
        host_model_inst.xbyte(8'h9F, dum);
        host_model_inst.xbyte(8'h00, r0);
        host_model_inst.xbyte(8'h00, r1);
        host_model_inst.sel(1'b1);
    endtask

    task automatic t_reset();
        check({gpd, mute, spiOn, sdoEnN}, 8'h0D);
        check(pwr, POWER_RST);
        @(posedge ref_clk);
        resetPinN <= 1'b1;
        repeat (16) @(posedge ref_clk);
        check({7'h00, mute}, 8'h01);
        repeat (30) @(posedge ref_clk);
        check({7'h00, mute}, 8'h00);
        $display("reset test done");
    endtask

    task automatic t_write();
        wr(8'h9E, 8'h02, 8'h00, 8'h00, 1);
        repeat (8) @(posedge ref_clk);
        check({6'h00, spiOn, gpd}, 8'h02);
        check(pwr, 8'h00);
        wr(8'h9A, 8'h02, 8'h01, 8'h01, 2);
        repeat (8) @(posedge ref_clk);
        check(pwr, 8'h00);
        check({7'h00, enSeen}, 8'h00);
        $display("write test done");
    endtask

    task automatic t_ptr();
        wr(8'h9E, 8'h02, 8'h00, 8'h01, 2);
        rd(8'h02);
        check(pwr, 8'h01);
        check(r0, 8'h01);
        check(r1, 8'h01);
        wr(8'h9E, 8'h84, 8'hA5, 8'h3C, 2);
        rd(8'h84);
        check(r0, 8'hA5);
        check(r1, 8'h3C);
        $display("pointer test done");
    endtask

    task automatic t_int();
        wr(8'h9E, 8'hA1, 8'h01, 8'h01, 2);
        check({7'h00, intPin}, 8'h01);
        intSrc <= 8'h01;
        repeat (4) @(posedge ref_clk);
        intSrc <= 8'h00;
        repeat (4) @(posedge ref_clk);
        check({7'h00, intPin}, 8'h00);
        rd(8'h20);
        check(r0, 8'h01);
        check(r1, 8'h00);
        check({7'h00, intPin}, 8'h01);
        wr(8'h9E, 8'h06, 8'h02, 8'h00, 1);
        wr(8'h9E, 8'h02, 8'h00, 8'h00, 1);
        check({7'h00, audioEn}, 8'h00);
        pllOk <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check({7'h00, audioEn}, 8'h01);
        $display("interrupt and pll test done");
    endtask

    task automatic t_i2c();
        logic ack;
        resetPinN <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check({6'h00, spiOn, pwr[0]}, 8'h01);
        resetPinN <= 1'b1;
        repeat (8) @(posedge ref_clk);
        host_model_inst.i2c_edge(1'b1);
        host_model_inst.i2c_byte(8'h9A, ack);
        check({7'h00, ack}, 8'h01);
        host_model_inst.i2c_byte(8'h02, ack);
        host_model_inst.i2c_byte(8'h00, ack);
        host_model_inst.i2c_edge(1'b0);
        check({6'h00, spiOn, pwr[0]}, 8'h00);
        $display("two-wire test done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        t_reset();
        t_write();
        t_ptr();
        t_int();
        t_i2c();
        give_verdict();
    end
endmodule // codec_control_port_tb_top
